// *** shared/dac_link_pkg.sv ***
/*
 * Shared constants for the two-wire code register link: addresses,
 * register field layout, mode encodings and timing counts.
 * Assumes a 100 MHz system clock on both ends of the link.
 */
`default_nettype none
package dac_link_pkg;
	// -------------------------------------------------------------
	// Addresses
	// -------------------------------------------------------------
	localparam logic [6:0] BASE_ADDR_FLOAT = 7'h0C;
	localparam logic [6:0] BASE_ADDR_GND = 7'h08;
	localparam logic [6:0] BASE_ADDR_SUPPLY = 7'h4C;
	localparam logic [6:0] BROADCAST_ADDR = 7'h48;
	localparam logic [4:0] HS_CODE_TOP = 5'h01;
	// -------------------------------------------------------------
	// Register layout
	// -------------------------------------------------------------
	localparam int REG_W = 16;
	localparam int CODE_W = 12;
	localparam int MODE_LSB = 12;
	localparam int MODE_MSB = 13;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_PD_2K5 = 2'h1;
	localparam logic [1:0] MODE_PD_100K = 2'h2;
	localparam logic [1:0] MODE_PD_HIZ = 2'h3;
	// Three-level selection input encoding.
	localparam logic [1:0] SEL_FLOAT = 2'h0;
	localparam logic [1:0] SEL_GND = 2'h1;
	localparam logic [1:0] SEL_SUPPLY = 2'h2;
	// -------------------------------------------------------------
	// Timing
	// -------------------------------------------------------------
	localparam int SYS_CLK_MHZ = 100;
	localparam int LINK_HALF_NS = 40;
	localparam int LINK_HALF_CYC = (LINK_HALF_NS * SYS_CLK_MHZ) / 1000;
	localparam int FIFO_DEPTH = 16;
endpackage
`default_nettype wire

// *** shared/dac_link_if.sv ***
/*
 * Two-wire link between master and target ends.
 * Assumes open-drain wires with pull-ups; resolved here from enables.
 */
`timescale 1ns/1ps
`default_nettype none
interface dac_link_if;
	logic scl_oe_m;
	logic sda_oe_m;
	logic sda_oe_s;
	logic scl;
	logic sda;
	// Open-drain resolution: any enabled driver pulls the wire low.
	assign scl = ~scl_oe_m;
	assign sda = ~(sda_oe_m | sda_oe_s);
	modport master (output scl_oe_m, output sda_oe_m, input scl,
		input sda);
	modport target (output sda_oe_s, input scl, input sda);
endinterface
`default_nettype wire

// *** logic/dac_target.sv ***
/*
 * Target end of the two-wire link holding the 16-bit code register.
 * Assumes the link wires are asynchronous and are synchronised here;
 * there is no reset other than arst_n_i acting as power-on.
 */
// What this block does
// - Acknowledge matching address after direction bit
// - Write takes upper byte then lower byte
// - Apply word at lower byte acknowledge
// - Accept repeated byte pairs until stop
// - Read shifts upper then lower byte
// - Master acks upper, nacks lower byte
// - Master code 00001XXX is not acknowledged
// - High speed persists until stop
// - Address from three-level selection inputs
// - Also respond to broadcast address
// - Lock address at first direct addressing
// - Register: zeros, mode, twelve-bit code
// - Power-up clears register, output zero
// - Nonzero mode field powers down
// - Powered-down register retained and readable
// - New write with zero mode field exits power-down, updates code
// - Drive data only for ack and read
`timescale 1ns/1ps
`default_nettype none
module dac_target (
	input wire logic clk_sys_i, // System clock.
	input wire logic arst_n_i, // Asynchronous active-low power-on reset.
	input wire logic ce_i, // Clock enable; freezes state when low.
	dac_link_if.target link, // Two-wire link.
	input wire logic [1:0] addr_select_low_i, // Low selection input.
	input wire logic [1:0] addr_select_high_i, // High selection input.
	output logic [11:0] analog_output_o, // Code applied to output.
	output logic powerdown_mode_hi_o, // Mode field upper bit.
	output logic powerdown_mode_lo_o, // Mode field lower bit.
	output logic powered_down_o, // Output stage shut down.
	output logic hs_mode_o, // Link is in high-speed mode.
	output logic addr_locked_o // Address latched.
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_WRITE = 3'b010,
		ST_READ = 3'b011,
		ST_RACK = 3'b100,
		ST_IGNORE = 3'b101
	} tgt_state_t;

	// -------------------------------------------------------------
	// Address decode
	// -------------------------------------------------------------
	// Base from high input plus offset from low input.
	function automatic logic [6:0] decode_addr(input logic [1:0] hi,
		input logic [1:0] lo);
		logic [6:0] base;
		base = dac_link_pkg::BASE_ADDR_FLOAT;
		if (hi == dac_link_pkg::SEL_GND) begin
			base = dac_link_pkg::BASE_ADDR_GND;
		end else if (hi == dac_link_pkg::SEL_SUPPLY) begin
			base = dac_link_pkg::BASE_ADDR_SUPPLY;
		end
		return base + {5'h00, lo};
	endfunction

	// -------------------------------------------------------------
	// Pin synchronisers and condition detection
	// -------------------------------------------------------------
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic scl_q;
	logic sda_q;
	// Both wires pass two flops; edges compare the second stage with a third flop.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (ce_i) begin
			scl_sync <= {scl_sync[0], link.scl};
			sda_sync <= {sda_sync[0], link.sda};
			scl_q <= scl_sync[1];
			sda_q <= sda_sync[1];
		end
	end
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_rise = scl_sync[1] & ~scl_q;
	assign scl_fall = ~scl_sync[1] & scl_q;
	assign start_det = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
	assign stop_det = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];

	// -------------------------------------------------------------
	// Byte engine
	// -------------------------------------------------------------
	tgt_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic in_ack;
	logic first_byte;
	logic is_read;
	logic low_half;
	logic [7:0] upper_hold;
	logic [15:0] code_reg;
	logic [6:0] own_addr;
	logic sda_drive;
	logic hit;
	logic bcast_hit;
	logic [7:0] rx_byte;
	logic [6:0] cur_addr;
	assign rx_byte = {shift[6:0], sda_sync[1]};
	assign cur_addr = addr_locked_o ? own_addr :
		decode_addr(addr_select_high_i, addr_select_low_i);
	// Decoded at the fall after the eighth bit, when shift holds the byte.
	assign hit = shift[7:1] == cur_addr;
	assign bcast_hit = shift[7:1] == dac_link_pkg::BROADCAST_ADDR;

	// Bits are sampled on rising clock, acks and read bits driven after fall.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= ST_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			in_ack <= 1'b0;
			is_read <= 1'b0;
			low_half <= 1'b0;
			upper_hold <= 8'h00;
			sda_drive <= 1'b0;
			first_byte <= 1'b0;
		end else if (ce_i) begin
			if (stop_det) begin
				state <= ST_IDLE;
				sda_drive <= 1'b0;
			end else if (start_det) begin
				state <= ST_ADDR;
				bit_cnt <= 4'h0;
				in_ack <= 1'b0;
				sda_drive <= 1'b0;
				first_byte <= 1'b1;
			end else if (scl_rise && !in_ack && state != ST_IDLE &&
				state != ST_IGNORE && state != ST_READ) begin
				shift <= rx_byte;
				bit_cnt <= bit_cnt + 4'h1;
			end else if (scl_rise && in_ack && state == ST_RACK) begin
				// Master nack ends the read; ack asks for the lower byte.
				state <= sda_sync[1] ? ST_IGNORE : ST_READ;
				shift <= code_reg[7:0];
				in_ack <= 1'b0;
			end else if (scl_rise && state == ST_READ) begin
				bit_cnt <= bit_cnt + 4'h1;
			end else if (scl_fall) begin
				unique case (state)
				ST_IDLE, ST_IGNORE: begin
					sda_drive <= 1'b0;
				end
				ST_ADDR: begin
					if (bit_cnt == 4'h8 && !in_ack) begin
						in_ack <= 1'b1;
						bit_cnt <= 4'h0;
						// Master code and mismatches get a nack.
						sda_drive <= hit | bcast_hit;
						is_read <= shift[0];
						if (!(hit | bcast_hit)) begin
							state <= ST_IGNORE;
						end
					end else if (in_ack) begin
						in_ack <= 1'b0;
						low_half <= 1'b0;
						if (is_read) begin
							state <= ST_READ;
							shift <= {2'h0, code_reg[13:8]};
							sda_drive <= ~code_reg[15];
						end else begin
							state <= ST_WRITE;
							sda_drive <= 1'b0;
						end
					end
				end
				ST_WRITE: begin
					if (bit_cnt == 4'h8 && !in_ack) begin
						in_ack <= 1'b1;
						bit_cnt <= 4'h0;
						sda_drive <= 1'b1;
						if (!low_half) begin
							upper_hold <= shift;
						end
					end else if (in_ack) begin
						in_ack <= 1'b0;
						sda_drive <= 1'b0;
						low_half <= ~low_half;
					end
				end
				ST_READ: begin
					if (bit_cnt == 4'h8) begin
						bit_cnt <= 4'h0;
						sda_drive <= 1'b0;
						in_ack <= 1'b1;
						state <= ST_RACK;
					end else begin
						sda_drive <= ~shift[3'h7 - bit_cnt[2:0]];
					end
				end
				ST_RACK: begin
					if (!in_ack) begin
						sda_drive <= ~shift[7];
						state <= ST_READ;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
				endcase
			end
		end
	end
	assign link.sda_oe_s = sda_drive;
	// The sda_drive flop feeds the wire enable directly.

	// -------------------------------------------------------------
	// Code register and output
	// -------------------------------------------------------------
	logic word_done;
	assign word_done = ce_i && scl_rise && in_ack && state == ST_WRITE &&
		low_half;
	// Complete word lands at the rising edge of the lower-byte ack.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			code_reg <= dac_link_pkg::REG_RESET;
		end else if (word_done) begin
			code_reg <= {2'h0, upper_hold[5:0], shift};
		end
	end
	// Outputs mirror the register; power-down holds code output at zero.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			analog_output_o <= 12'h000;
			powerdown_mode_hi_o <= 1'b0;
			powerdown_mode_lo_o <= 1'b0;
			powered_down_o <= 1'b0;
		end else if (word_done) begin
			powerdown_mode_hi_o <= upper_hold[5];
			powerdown_mode_lo_o <= upper_hold[4];
			powered_down_o <= |upper_hold[5:4];
			analog_output_o <= (|upper_hold[5:4]) ? 12'h000 :
				{upper_hold[3:0], shift};
		end
	end

	// -------------------------------------------------------------
	// Address lock and speed mode tracking
	// -------------------------------------------------------------
	// Lock only on a direct, non-broadcast match.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			own_addr <= 7'h00;
			addr_locked_o <= 1'b0;
			hs_mode_o <= 1'b0;
		end else if (ce_i) begin
			if (scl_fall && state == ST_ADDR && bit_cnt == 4'h8 &&
				!in_ack) begin
				if (hit && !addr_locked_o) begin
					own_addr <= cur_addr;
					addr_locked_o <= 1'b1;
				end
				if (shift[7:3] == dac_link_pkg::HS_CODE_TOP) begin
					hs_mode_o <= 1'b1;
				end
			end
			if (stop_det) begin
				hs_mode_o <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// *** logic/dac_master.sv ***
/*
 * Master end: a FIFO of 16-bit words, each written to the target as
 * an upper/lower byte pair, plus single-word reads.
 * Assumes a 100 MHz clock; the link clock is divided from it.
 */
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys_i, // System clock.
	input wire logic arst_n_i, // Asynchronous reset, active low.
	input wire logic ce_i, // Clock enable.
	input wire logic [WIDTH-1:0] in_data_i, // Write data.
	input wire logic in_valid_i, // Write valid.
	output logic in_ready_o, // Room available.
	output logic [WIDTH-1:0] out_data_o, // Read data.
	output logic out_valid_o, // Data available.
	input wire logic out_ready_i // Consumer takes word.
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic push;
	logic pop;
	assign push = ce_i & in_valid_i & in_ready_o;
	assign pop = ce_i & out_valid_o & out_ready_i;
	assign in_ready_o = (wr_ptr - rd_ptr) != (AW + 1)'(DEPTH);
	assign out_valid_o = wr_ptr != rd_ptr;
	assign out_data_o = mem[rd_ptr[AW-1:0]];
	// Storage has no reset; only pointers define contents.
	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data_i;
		end
	end
	// Extra pointer bit tells full from empty.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= wr_ptr + (AW + 1)'(push);
			rd_ptr <= rd_ptr + (AW + 1)'(pop);
		end
	end
endmodule

module dac_master (
	input wire logic clk_sys_i, // System clock.
	input wire logic arst_n_i, // Asynchronous active-low reset.
	input wire logic ce_i, // Clock enable.
	dac_link_if.master link, // Two-wire link.
	input wire logic [6:0] target_addr_i, // Target address.
	input wire logic hs_enter_i, // Send master code first.
	input wire logic [15:0] wr_data_i, // Word to write.
	input wire logic wr_valid_i, // Word offered.
	output logic wr_ready_o, // FIFO has room.
	input wire logic rd_req_i, // Request single read.
	output logic [15:0] rd_data_o, // Read result.
	output logic rd_done_o, // Read finished pulse.
	output logic busy_o, // Transfer in progress.
	output logic nack_o // Last address was refused.
);
	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_START = 3'b001,
		M_BYTE = 3'b010,
		M_ACK = 3'b011,
		M_STOP = 3'b100,
		M_END = 3'b101
	} m_state_t;
	logic [15:0] f_data;
	logic f_valid;
	logic f_pop;
	word_fifo #(.WIDTH(16), .DEPTH(dac_link_pkg::FIFO_DEPTH)) fifo (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.in_data_i(wr_data_i),
		.in_valid_i(wr_valid_i),
		.in_ready_o(wr_ready_o),
		.out_data_o(f_data),
		.out_valid_o(f_valid),
		.out_ready_i(f_pop)
	);
	// -------------------------------------------------------------
	// Sequencer: one phase per half link period
	// -------------------------------------------------------------
	m_state_t state;
	logic [7:0] div;
	logic phase;
	logic [7:0] tx;
	logic [2:0] nbit;
	logic [2:0] step;
	logic reading;
	logic hs_pending;
	logic tick;
	assign tick = div == 8'(dac_link_pkg::LINK_HALF_CYC - 1);
	// A word leaves after its upper byte so that the next one is visible
	// when the lower byte ends; a refused address drops the word.
	assign f_pop = ce_i && tick && phase && state == M_ACK && !reading &&
		(step == 3'h2 || (step == 3'h0 && link.sda)) && f_valid;
	// Step: 0 addr, 1 master code, 2 upper, 3 lower, 4 read upper, 5 lower.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= M_IDLE;
			div <= 8'h00;
			phase <= 1'b0;
			tx <= 8'h00;
			nbit <= 3'h0;
			step <= 3'h0;
			reading <= 1'b0;
			hs_pending <= 1'b0;
			link.scl_oe_m <= 1'b0;
			link.sda_oe_m <= 1'b0;
			rd_data_o <= 16'h0000;
			rd_done_o <= 1'b0;
			busy_o <= 1'b0;
			nack_o <= 1'b0;
		end else if (ce_i) begin
			rd_done_o <= 1'b0;
			div <= tick ? 8'h00 : div + 8'h01;
			if (state == M_IDLE) begin
				if (f_valid || rd_req_i) begin
					state <= M_START;
					busy_o <= 1'b1;
					reading <= ~f_valid;
					hs_pending <= hs_enter_i;
					phase <= 1'b0;
				end
			end else if (tick) begin
				phase <= ~phase;
				unique case (state)
				M_START: begin
					// Data falls while clock is high, then clock falls.
					if (!phase) begin
						link.scl_oe_m <= 1'b0;
						link.sda_oe_m <= 1'b1;
					end else begin
						link.scl_oe_m <= 1'b1;
						state <= M_BYTE;
						nbit <= 3'h7;
						step <= hs_pending ? 3'h1 : 3'h0;
						tx <= hs_pending ? 8'h08 :
							{target_addr_i, reading};
						hs_pending <= 1'b0;
					end
				end
				M_BYTE: begin
					if (!phase) begin
						link.scl_oe_m <= 1'b1;
					end else begin
						link.scl_oe_m <= 1'b0;
						if (step >= 3'h4) begin
							rd_data_o <= {rd_data_o[14:0], link.sda};
						end
						if (nbit == 3'h0) begin
							state <= M_ACK;
						end
						nbit <= nbit - 3'h1;
					end
				end
				M_ACK: begin
					if (!phase) begin
						link.scl_oe_m <= 1'b1;
					end else begin
						link.scl_oe_m <= 1'b0;
						nbit <= 3'h7;
						state <= M_BYTE;
						if (step <= 3'h1 && link.sda) begin
							nack_o <= step == 3'h0;
							state <= step == 3'h1 ? M_START : M_STOP;
						end else if (step == 3'h0) begin
							nack_o <= 1'b0;
							step <= reading ? 3'h4 : 3'h2;
							tx <= f_data[15:8];
						end else if (step == 3'h2) begin
							step <= 3'h3;
							tx <= f_data[7:0];
						end else if (step == 3'h3 && f_valid) begin
							step <= 3'h2;
							tx <= f_data[15:8];
						end else if (step == 3'h4) begin
							step <= 3'h5;
						end else begin
							state <= M_STOP;
							rd_done_o <= reading;
						end
					end
				end
				M_STOP: begin
					// Clock low, data low inside the half, then clock high.
					if (!phase) begin
						link.scl_oe_m <= 1'b1;
					end else begin
						link.scl_oe_m <= 1'b0;
						state <= M_END;
					end
				end
				M_END: begin
					// Data rises while the clock is high: the stop.
					link.sda_oe_m <= 1'b0;
					state <= M_IDLE;
					busy_o <= 1'b0;
				end
				default: begin
					state <= M_IDLE;
				end
				endcase
			end else if (phase && div == 8'h02) begin
				// Data moves inside the low half, on the same clock edge where the target
				// lets go, so both ends never pull the wire at once.
				if (state == M_BYTE) begin
					link.sda_oe_m <= step >= 3'h4 ? 1'b0 : ~tx[nbit];
				end else if (state == M_ACK) begin
					// Ack the upper read byte, nack the lower one.
					link.sda_oe_m <= step == 3'h4;
				end else if (state == M_STOP) begin
					link.sda_oe_m <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** test/dac_link_sva.sv ***
/*
 * Checker for the wires of the two-wire link between the two ends.
 * Assumes it sits beside the interface and runs on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module dac_link_sva (
	input wire logic clk_sys_i, // System clock.
	input wire logic arst_n_i, // Reset, active low.
	input wire logic scl_oe_m, // Master clock drive.
	input wire logic sda_oe_m, // Master data drive.
	input wire logic sda_oe_s, // Target data drive.
	input wire logic scl, // Resolved clock wire.
	input wire logic sda // Resolved data wire.
);
	logic scl_q, sda_q, rd, acked, rise, start;
	logic [3:0] cnt;
	logic [1:0] nbyte;
	logic [7:0] sh;
	// -------------------------------------------------------------
	// Frame tracking
	// -------------------------------------------------------------
	// Edges are found by comparing with the previous sample.
	assign rise = scl & ~scl_q;
	assign start = scl & scl_q & sda_q & ~sda;
	// Previous wire levels.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end
	// Bit and byte position; the byte count saturates to keep it small.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt <= 4'h0;
			nbyte <= 2'h0;
			sh <= 8'h00;
			rd <= 1'b0;
			acked <= 1'b0;
		end else if (start) begin
			cnt <= 4'h0;
			nbyte <= 2'h0;
		end else if (rise && cnt == 4'h8) begin
			cnt <= 4'h0;
			if (nbyte != 2'h3) nbyte <= nbyte + 2'h1;
			if (nbyte == 2'h0) acked <= ~sda;
			if (nbyte == 2'h0) rd <= sh[0];
		end else if (rise) begin
			cnt <= cnt + 4'h1;
			sh <= {sh[6:0], sda};
		end
	end
	// -------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	a_no_contention: assert property (!(sda_oe_m && sda_oe_s))
		else $error("Both ends drive the data wire.");
	a_target_edge: assert property ($changed(sda_oe_s) |-> !scl)
		else $error("Target changed data while clock high.");
	a_drive_slot: assert property ($rose(sda_oe_s) |->
		(cnt == 4'h8 && !(rd && nbyte != 2'h0)) ||
		(rd && acked && (nbyte == 2'h1 || nbyte == 2'h2) && cnt != 4'h8))
		else $error("Target drove data outside its slots.");
	a_hs_nack: assert property (rise && cnt == 4'h8 && nbyte == 2'h0 &&
		sh[7:3] == dac_link_pkg::HS_CODE_TOP |-> sda)
		else $error("Master code was acknowledged.");
	a_bcast_ack: assert property (rise && cnt == 4'h8 && nbyte == 2'h0 &&
		sh[7:1] == dac_link_pkg::BROADCAST_ADDR |-> !sda)
		else $error("Broadcast address not acknowledged.");
	a_data_ack: assert property (rise && cnt == 4'h8 && nbyte != 2'h0 &&
		acked && !rd |-> !sda)
		else $error("Written byte not acknowledged.");
	a_read_ack: assert property (rise && cnt == 4'h8 && rd && acked &&
		nbyte == 2'h1 |-> !sda)
		else $error("Master did not acknowledge upper byte.");
	a_read_nack: assert property (rise && cnt == 4'h8 && rd && acked &&
		nbyte == 2'h2 |-> sda)
		else $error("Master acknowledged lower byte.");
	a_nack_silent: assert property (nbyte != 2'h0 && !acked |-> !sda_oe_s)
		else $error("Target drove data after refusing address.");
endmodule
`default_nettype wire

// *** test/i2c_dac_code_register_slave_tb.sv ***
/*
 * Bench joining the master and target ends through the link interface.
 * Assumes the package, interface and both design files are compiled.
 */
`timescale 1ns/1ps
`default_nettype none
module i2c_dac_code_register_slave_tb;
	logic clk_sys_i = 1'b0, arst_n_i = 1'b0, hs_enter_i = 1'b0;
	logic wr_valid_i = 1'b0, rd_req_i = 1'b0, hs_seen = 1'b0;
	logic [1:0] sel_lo = 2'h0, sel_hi = 2'h0;
	logic [6:0] target_addr_i = 7'h00;
	logic [15:0] wr_data_i = 16'h0000;
	logic [11:0] code, prev;
	logic mode_hi, mode_lo, pd, hs, locked, wr_ready, rd_done, busy, nack;
	logic [15:0] rd_data;
	int num_errors = 0, checked = 0, upd = 0;
	// -------------------------------------------------------------
	// Structure
	// -------------------------------------------------------------
	always #5 clk_sys_i = ~clk_sys_i;
	dac_link_if link();
	dac_target i_dac_target (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
		.ce_i(1'b1), .link(link), .addr_select_low_i(sel_lo),
		.addr_select_high_i(sel_hi), .analog_output_o(code),
		.powerdown_mode_hi_o(mode_hi), .powerdown_mode_lo_o(mode_lo),
		.powered_down_o(pd), .hs_mode_o(hs), .addr_locked_o(locked));
	dac_master i_dac_master (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
		.ce_i(1'b1), .link(link), .target_addr_i(target_addr_i),
		.hs_enter_i(hs_enter_i), .wr_data_i(wr_data_i),
		.wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready),
		.rd_req_i(rd_req_i), .rd_data_o(rd_data), .rd_done_o(rd_done),
		.busy_o(busy), .nack_o(nack));
	dac_link_sva i_dac_link_sva (.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i), .scl_oe_m(link.scl_oe_m),
		.sda_oe_m(link.sda_oe_m), .sda_oe_s(link.sda_oe_s),
		.scl(link.scl), .sda(link.sda));
	// -------------------------------------------------------------
	// Tasks
	// -------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Waits for a transfer to start and end; the start wait is short.
	task automatic settle();
		int n;
		n = 0;
		while (busy !== 1'b1 && n < 50) begin
			@(posedge clk_sys_i);
			n++;
		end
		n = 0;
		while (busy !== 1'b0 && n < 8000) begin
			@(posedge clk_sys_i);
			n++;
		end
		check({15'h0, busy}, 16'h0000);
		repeat (8) @(negedge clk_sys_i);
	endtask
	task automatic do_reset(input logic [1:0] hi, input logic [1:0] lo);
		@(negedge clk_sys_i);
		arst_n_i = 1'b0;
		sel_hi = hi;
		sel_lo = lo;
		repeat (2) @(negedge clk_sys_i);
		arst_n_i = 1'b1;
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(negedge clk_sys_i);
		target_addr_i = a;
		wr_data_i = d;
		wr_valid_i = 1'b1;
		while (wr_ready !== 1'b1) @(negedge clk_sys_i);
		@(negedge clk_sys_i);
		wr_valid_i = 1'b0;
		settle();
	endtask
	task automatic rd(input logic [6:0] a, output logic [15:0] d);
		@(negedge clk_sys_i);
		target_addr_i = a;
		rd_req_i = 1'b1;
		do @(negedge clk_sys_i); while (busy !== 1'b1);
		rd_req_i = 1'b0;
		// The done pulse is looked at mid-cycle, while it stands.
		do @(negedge clk_sys_i); while (rd_done !== 1'b1);
		d = rd_data;
		settle();
	endtask
	// -------------------------------------------------------------
	// Monitors and tests
	// -------------------------------------------------------------
	// Counts output updates; sampled mid-cycle so flop updates have landed.
	always @(negedge clk_sys_i) begin
		if (hs === 1'b1) hs_seen = 1'b1;
		if (code !== prev) upd++;
		prev = code;
	end
	// Cuts a hang short well beyond the expected run length.
	initial begin
		#600000;
		num_errors++;
		$display("[FAIL] t=%0t watchdog %h exp %h", $time, 1'b1, 1'b0);
		close_out();
	end
	initial begin
		logic [15:0] r;
		logic [6:0] a;
		int n, u0;
		do_reset(2'h0, 2'h0);
		wr(dac_link_pkg::BROADCAST_ADDR, 16'h0123);
		check({4'h0, code}, 16'h0123);
		check({15'h0, locked}, 16'h0000);
		for (int h = 0; h < 3; h++) begin
			for (int l = 0; l < 3; l++) begin
				do_reset(h[1:0], l[1:0]);
				check({4'h0, code}, 16'h0000);
				a = (h == 0 ? dac_link_pkg::BASE_ADDR_FLOAT : h == 1 ?
					dac_link_pkg::BASE_ADDR_GND :
					dac_link_pkg::BASE_ADDR_SUPPLY) + 7'(l);
				wr(a ^ 7'h03, 16'h0555);
				check({15'h0, nack}, 16'h0001);
				check({4'h0, code}, 16'h0000);
				wr(a, 16'h0800 + 16'(h * 3 + l));
				check({15'h0, nack}, 16'h0000);
				check({4'h0, code}, 16'h0800 + 16'(h * 3 + l));
				check({15'h0, locked}, 16'h0001);
			end
		end
		sel_hi = 2'h0;
		sel_lo = 2'h0;
		wr(7'h4E, 16'h0321);
		check({4'h0, code}, 16'h0321);
		wr(7'h0C, 16'h0777);
		check({15'h0, nack}, 16'h0001);
		for (int m = 0; m < 4; m++) begin
			wr(7'h4E, {2'b11, m[1:0], 12'hA5C});
			check({14'h0, mode_hi, mode_lo}, 16'(m));
			check({15'h0, pd}, 16'(m != 0));
			check({4'h0, code}, m == 0 ? 16'h0A5C : 16'h0000);
			rd(7'h4E, r);
			check(r, {2'b00, m[1:0], 12'hA5C});
		end
		wr(7'h4E, 16'h0BEE);
		check({3'h0, pd, code}, 16'h0BEE);
		hs_enter_i = 1'b1;
		hs_seen = 1'b0;
		wr(7'h4E, 16'h0CAB);
		hs_enter_i = 1'b0;
		check({15'h0, hs_seen}, 16'h0001);
		check({15'h0, hs}, 16'h0000);
		check({4'h0, code}, 16'h0CAB);
		// Fill the buffer until it refuses, then let it drain.
		u0 = upd;
		n = 0;
		target_addr_i = 7'h4E;
		while (n < 24) begin
			@(negedge clk_sys_i);
			wr_data_i = 16'h0100 + 16'(n);
			if (wr_ready !== 1'b1) break;
			wr_valid_i = 1'b1;
			n++;
		end
		wr_valid_i = 1'b0;
		check(16'(n >= 16 && n <= 17), 16'h0001);
		settle();
		check(16'(upd - u0), 16'(n));
		check({4'h0, code}, 16'h00FF + 16'(n));
		close_out();
	end
endmodule
`default_nettype wire
